// ==== fswp_protect.sv ====
// Sector lock, block-range and status-lock protection decisions
//
// Notes on behaviour
// - Sector lock or block range, either one, protects a sector.
// - One lock register per 64 KB sector, sectors 0 to 127.
// - Read-lock returns, write-lock updates, the addressed sector's bits.
// - Each lock register holds a write-lock bit and a lock-down bit.
// - Write-lock 1 makes every modify of that sector fail, data unchanged.
// - Write-lock 0 leaves only the block range able to protect.
// - Lock-down 1 ignores any change to that sector's lock bits.
// - Only power-up clears lock-down; the bits stay frozen until then.
// - Lock-down 0: write-lock freely sets or clears protection.
// - Lock-down 1: protection follows write-lock, fixed until power-up.
// - Four size bits and a side bit select a read-only range.
// - Side 0: codes 1 to 7 protect the top 1 to 64 sectors.
// - Side 1: codes 1 to 7 protect the bottom 1 to 64 sectors.
// - Size bit 3 set protects every sector.
// - The write-protect pin adds a hardware lock over the range.
// - Hardware lock refuses status writes to size and disable bits.
// - Error flag sets on protected modify, OTP or status write.
// - Only clear-flag or power-up clears the flag; until then, modify, lock, status and OTP requests fail.
// - Lock writes need the write-enable latch; completion clears it.
// - Lock needs disable bit plus pin; a refused write is a violation.
`default_nettype none
module fswp_protect
  import fswp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic op_valid_i,
  input wire fswp_op_t op_kind_i,
  input wire logic [FSWP_SEC_W-1:0] op_sector_i,
  input wire logic [1:0] lock_wdata_i,
  input wire logic [FSWP_BP_MSB:0] range_size_i,
  input wire logic range_side_select_i,
  input wire logic status_write_disable_i,
  input wire logic wp_n_i,
  input wire logic otp_locked_i,
  output logic op_done_o,
  output fswp_res_t op_result_o,
  output logic [1:0] lock_rdata_o,
  output logic prot_error_o,
  output logic write_enable_latch_o,
  output logic [FSWP_BP_MSB:0] range_size_o,
  output logic range_side_select_o,
  output logic status_write_disable_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [FSWP_SECTORS-1:0][1:0] lock;
    logic [FSWP_BP_MSB:0] bp;
    logic tb;
    logic status_write_disable;
    logic write_enable_latch;
    logic prot_err;
    logic done;
    fswp_res_t res;
    logic [1:0] lock_rd;
  } fswp_state_t;

  localparam fswp_state_t FSWP_ST_RST = '{
    lock: {FSWP_SECTORS{FSWP_LOCK_RST}},
    bp: FSWP_BP_RST,
    tb: FSWP_TB_RST,
    status_write_disable: FSWP_STATUS_WRITE_DISABLE_RST,
    write_enable_latch: 1'b0,
    prot_err: 1'b0,
    done: 1'b0,
    res: FSWP_RES_OK,
    lock_rd: FSWP_LOCK_RST
  };

  fswp_state_t st_r;
  fswp_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Range decode for the modify check
  function automatic logic range_hit(
    input logic [FSWP_SEC_W-1:0] sec,
    input logic [FSWP_BP_MSB:0] bp,
    input logic tb
  );
    logic [7:0] cnt;
    logic [7:0] s8;
    cnt = FSWP_ONE << (bp[FSWP_BP_MSB-1:0] - 3'h1);
    s8 = {1'b0, sec};
    if (bp[FSWP_BP_MSB]) begin
      range_hit = 1'b1;
    end else if (bp[FSWP_BP_MSB-1:0] == FSWP_SIZE_NONE) begin
      range_hit = 1'b0;
    end else if (tb) begin
      range_hit = s8 < cnt;
    end else begin
      range_hit = s8 >= (FSWP_SEC_CNT - cnt);
    end
  endfunction

  logic [1:0] sec_lock;
  logic sec_prot;
  logic hw_lock;

  // Range and lock are ORed so neither scheme can weaken the other
  assign sec_lock = st_r.lock[op_sector_i];
  assign sec_prot = sec_lock[FSWP_LK_WL] |
                    range_hit(op_sector_i, st_r.bp, st_r.tb);
  assign hw_lock = st_r.status_write_disable & ~wp_n_i;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = op_valid_i && (op_kind_i != FSWP_OP_NONE);
    st_nxt.res = FSWP_RES_OK;
    if (op_valid_i) begin
      case (op_kind_i)
        FSWP_OP_MODIFY: begin
          if (!st_r.write_enable_latch) begin
            st_nxt.res = FSWP_RES_IGNORED;
          end else begin
            st_nxt.write_enable_latch = 1'b0;
            // A pending error makes the next modify fail until cleared
            if (st_r.prot_err || sec_prot) begin
              st_nxt.res = FSWP_RES_REFUSED;
              st_nxt.prot_err = 1'b1;
            end
          end
        end
        FSWP_OP_RD_LOCK: begin
          st_nxt.lock_rd = sec_lock;
        end
        FSWP_OP_WR_LOCK: begin
          if (!st_r.write_enable_latch) begin
            st_nxt.res = FSWP_RES_IGNORED;
          end else begin
            st_nxt.write_enable_latch = 1'b0;
            if (sec_lock[FSWP_LK_LD]) begin
              st_nxt.res = FSWP_RES_IGNORED;
            end else if (st_r.prot_err) begin
              st_nxt.res = FSWP_RES_REFUSED;
            end else begin
              st_nxt.lock[op_sector_i] = lock_wdata_i;
            end
          end
        end
        FSWP_OP_WR_STATUS: begin
          if (!st_r.write_enable_latch) begin
            st_nxt.res = FSWP_RES_IGNORED;
          end else begin
            st_nxt.write_enable_latch = 1'b0;
            if (hw_lock || st_r.prot_err) begin
              st_nxt.res = FSWP_RES_REFUSED;
              st_nxt.prot_err = 1'b1;
            end else begin
              st_nxt.bp = range_size_i;
              st_nxt.tb = range_side_select_i;
              st_nxt.status_write_disable = status_write_disable_i;
            end
          end
        end
        FSWP_OP_CLR_FLAG: begin
          st_nxt.prot_err = 1'b0;
        end
        FSWP_OP_WR_EN: begin
          st_nxt.write_enable_latch = 1'b1;
        end
        FSWP_OP_OTP_PROG: begin
          if (!st_r.write_enable_latch) begin
            st_nxt.res = FSWP_RES_IGNORED;
          end else begin
            st_nxt.write_enable_latch = 1'b0;
            if (otp_locked_i || st_r.prot_err) begin
              st_nxt.res = FSWP_RES_REFUSED;
              st_nxt.prot_err = 1'b1;
            end
          end
        end
        default: begin
          st_nxt.done = 1'b0;
        end
      endcase
    end
  end

  // Reset stands for power-up: the only way lock-down is released
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_r <= FSWP_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign op_done_o = st_r.done;
  assign op_result_o = st_r.res;
  assign lock_rdata_o = st_r.lock_rd;
  assign prot_error_o = st_r.prot_err;
  assign write_enable_latch_o = st_r.write_enable_latch;
  assign range_size_o = st_r.bp;
  assign range_side_select_o = st_r.tb;
  assign status_write_disable_o = st_r.status_write_disable;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_req(fswp_op_t k);
    op_valid_i && op_kind_i == k && st_r.write_enable_latch;
  endsequence

  sequence s_refused_err;
    op_done_o && op_result_o == FSWP_RES_REFUSED && prot_error_o;
  endsequence

  a_write_lock_blocks: assert property (
    s_req(FSWP_OP_MODIFY) and sec_lock[FSWP_LK_WL] |=> s_refused_err)
    else $error("modify of write-locked sector not refused");

  a_range_all_prot: assert property (
    s_req(FSWP_OP_MODIFY) and st_r.bp[FSWP_BP_MSB] |=> s_refused_err)
    else $error("modify with full range protection not refused");

  a_unprot_modify: assert property (
    s_req(FSWP_OP_MODIFY) and !st_r.prot_err && !sec_prot
    |=> op_done_o && op_result_o == FSWP_RES_OK && !write_enable_latch_o)
    else $error("unprotected modify did not succeed");

  a_lockdown_frozen: assert property (
    op_valid_i && op_kind_i == FSWP_OP_WR_LOCK && sec_lock[FSWP_LK_LD]
    |=> st_r.lock[$past(op_sector_i)] == $past(sec_lock))
    else $error("locked-down sector bits changed");

  a_lock_wel_clear: assert property (
    s_req(FSWP_OP_WR_LOCK) |=> !write_enable_latch_o ##1
      (write_enable_latch_o == $past(op_valid_i &&
        op_kind_i == FSWP_OP_WR_EN)))
    else $error("write-enable latch not cleared after lock write");

  a_hw_status_lock: assert property (
    s_req(FSWP_OP_WR_STATUS) and hw_lock
    |=> s_refused_err and $stable(range_size_o) &&
      $stable(status_write_disable_o))
    else $error("status write under hardware lock not refused");

  a_flag_sticky: assert property (
    prot_error_o && !(op_valid_i && op_kind_i == FSWP_OP_CLR_FLAG)
    |=> prot_error_o)
    else $error("protection flag dropped without clear");

  a_flag_clear: assert property (
    op_valid_i && op_kind_i == FSWP_OP_CLR_FLAG |=> !prot_error_o)
    else $error("clear-flag did not clear protection flag");

  a_lock_read: assert property (
    op_valid_i && op_kind_i == FSWP_OP_RD_LOCK
    |=> lock_rdata_o == $past(sec_lock) && op_done_o)
    else $error("lock read returned wrong bits");

  sequence s_ok_done;
    op_done_o && op_result_o == FSWP_RES_OK;
  endsequence

  sequence s_ignored;
    op_done_o && op_result_o == FSWP_RES_IGNORED;
  endsequence

  // Fixed sectors at the range edges keep these apart from the decode
  a_top_code_one: assert property (
    s_req(FSWP_OP_MODIFY) and !st_r.tb && st_r.bp == 4'h1 &&
      op_sector_i == 7'h7F |=> s_refused_err)
    else $error("top sector not protected by size code 1");

  a_half_range_edge: assert property (
    s_req(FSWP_OP_MODIFY) and !st_r.tb && st_r.bp == 4'h7 &&
      op_sector_i == 7'h3F && !sec_lock[FSWP_LK_WL] && !st_r.prot_err
    |=> s_ok_done)
    else $error("sector below the upper half was protected");

  a_bottom_code_one: assert property (
    s_req(FSWP_OP_MODIFY) and st_r.tb && st_r.bp == 4'h1 &&
      op_sector_i == 7'h00 |=> s_refused_err)
    else $error("bottom sector not protected by size code 1");

  a_otp_locked_err: assert property (
    s_req(FSWP_OP_OTP_PROG) and otp_locked_i |=> s_refused_err)
    else $error("program of locked OTP area not refused");

  a_flag_blocks_lock: assert property (
    s_req(FSWP_OP_WR_LOCK) and st_r.prot_err && !sec_lock[FSWP_LK_LD]
    |=> op_done_o && op_result_o == FSWP_RES_REFUSED &&
      st_r.lock[$past(op_sector_i)] == $past(sec_lock))
    else $error("lock write with pending error not refused");

  a_no_latch_ignored: assert property (
    op_valid_i && op_kind_i == FSWP_OP_WR_LOCK && !st_r.write_enable_latch
    |=> s_ignored and st_r.lock == $past(st_r.lock))
    else $error("lock write without write-enable latch not ignored");

  a_status_wel_clear: assert property (
    s_req(FSWP_OP_WR_STATUS) |=> !write_enable_latch_o)
    else $error("write-enable latch not cleared after status write");

  a_lockdown_no_err: assert property (
    s_req(FSWP_OP_WR_LOCK) and sec_lock[FSWP_LK_LD]
    |=> s_ignored and prot_error_o == $past(prot_error_o))
    else $error("lock write to locked-down sector not ignored");

  a_status_accept: assert property (
    s_req(FSWP_OP_WR_STATUS) and !hw_lock && !st_r.prot_err
    |=> s_ok_done and range_size_o == $past(range_size_i))
    else $error("status write without hardware lock not applied");

endmodule
`default_nettype wire

// ==== fswp_pkg.sv ====
// Constants and types for the flash sector write-protection block
`default_nettype none
package fswp_pkg;
  localparam int FSWP_SECTORS = 128;
  localparam int FSWP_SEC_W = 7;
  localparam logic [7:0] FSWP_SEC_CNT = 8'h80;
  localparam int FSWP_LK_WL = 0;
  localparam int FSWP_LK_LD = 1;
  localparam logic [1:0] FSWP_LOCK_RST = 2'h0;
  localparam int FSWP_BP_MSB = 3;
  localparam logic [3:0] FSWP_BP_RST = 4'h0;
  localparam logic [2:0] FSWP_SIZE_NONE = 3'h0;
  localparam logic [7:0] FSWP_ONE = 8'h01;
  localparam logic FSWP_TB_RST = 1'b0;
  localparam logic FSWP_STATUS_WRITE_DISABLE_RST = 1'b0;
  localparam int FSWP_FLAG_PROT_BIT = 1;

  typedef enum logic [2:0] {
    FSWP_OP_NONE = 3'b000,
    FSWP_OP_MODIFY = 3'b001,
    FSWP_OP_RD_LOCK = 3'b010,
    FSWP_OP_WR_LOCK = 3'b011,
    FSWP_OP_WR_STATUS = 3'b100,
    FSWP_OP_CLR_FLAG = 3'b101,
    FSWP_OP_WR_EN = 3'b110,
    FSWP_OP_OTP_PROG = 3'b111
  } fswp_op_t;

  typedef enum logic [1:0] {
    FSWP_RES_OK = 2'b00,
    FSWP_RES_REFUSED = 2'b01,
    FSWP_RES_IGNORED = 2'b10
  } fswp_res_t;
endpackage
`default_nettype wire

// ==== fswp_host.sv ====
// Host model that issues one protection request at a time
`default_nettype none
module fswp_host
  import fswp_pkg::*;
(
  input wire logic clk_i,
  output logic valid_o,
  output fswp_op_t kind_o,
  output logic [6:0] sec_o,
  output logic [1:0] wd_o,
  output logic [5:0] st_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    valid_o = 1'b0;
    kind_o = FSWP_OP_NONE;
    sec_o = 7'h00;
    wd_o = 2'h0;
    st_o = 6'h00;
  end
  // Held for one edge; released sector and lock-data lines show inverted data, status lines keep theirs
  task automatic req(input fswp_op_t k, input logic [6:0] s,
      input logic [1:0] w, input logic [5:0] st);
    @(posedge clk_i);
    valid_o <= 1'b1;
    kind_o <= k;
    sec_o <= s;
    wd_o <= w;
    st_o <= st;
    @(posedge clk_i);
    valid_o <= 1'b0;
    kind_o <= FSWP_OP_NONE;
    sec_o <= ~s;
    wd_o <= ~w;
    #1;
  endtask
  // Optional latch set first, as every modifying request needs it
  task automatic send(input logic we, input fswp_op_t k,
      input logic [6:0] s, input logic [1:0] w, input logic [5:0] st);
    if (we) begin
      req(FSWP_OP_WR_EN, 7'h00, 2'h0, 6'h00);
    end
    req(k, s, w, st);
  endtask
endmodule
`default_nettype wire

// ==== flash_sector_write_protection_bench.sv ====
// Self-checking bench for the sector write-protection block
`default_nettype none
module flash_sector_write_protection_bench;
  import fswp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic we;
    fswp_op_t k;
    logic [6:0] s;
    logic [1:0] w;
    fswp_res_t r;
    logic e;
    logic [1:0] rd;
  } fswp_row_t;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic otp_locked_i = 1'b0;
  wire logic op_valid_i;
  wire fswp_op_t op_kind_i;
  wire logic [6:0] op_sector_i;
  wire logic [1:0] lock_wdata_i;
  wire logic [5:0] st;
  logic op_done_o, prot_error_o, write_enable_latch_o;
  logic range_side_select_o, status_write_disable_o;
  logic [1:0] lock_rdata_o;
  logic [3:0] range_size_o;
  fswp_res_t op_result_o;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] n;
  logic [7:0] sv [4];
  logic [6:0] sc;
  localparam fswp_res_t RES_OK = FSWP_RES_OK;
  localparam fswp_res_t RES_REF = FSWP_RES_REFUSED;
  localparam fswp_res_t RES_IGN = FSWP_RES_IGNORED;
  fswp_row_t rows [15] = '{
    '{1'b1, FSWP_OP_WR_LOCK, 7'h05, 2'h1, RES_OK, 1'b0, 2'h0},
    '{1'b0, FSWP_OP_RD_LOCK, 7'h05, 2'h0, RES_OK, 1'b0, 2'h1},
    '{1'b1, FSWP_OP_MODIFY, 7'h05, 2'h0, RES_REF, 1'b1, 2'h1},
    '{1'b0, FSWP_OP_CLR_FLAG, 7'h05, 2'h0, RES_OK, 1'b0, 2'h1},
    '{1'b1, FSWP_OP_WR_LOCK, 7'h05, 2'h0, RES_OK, 1'b0, 2'h1},
    '{1'b1, FSWP_OP_MODIFY, 7'h05, 2'h0, RES_OK, 1'b0, 2'h1},
    '{1'b1, FSWP_OP_WR_LOCK, 7'h05, 2'h3, RES_OK, 1'b0, 2'h1},
    '{1'b1, FSWP_OP_WR_LOCK, 7'h05, 2'h0, RES_IGN, 1'b0, 2'h1},
    '{1'b0, FSWP_OP_RD_LOCK, 7'h05, 2'h0, RES_OK, 1'b0, 2'h3},
    '{1'b0, FSWP_OP_MODIFY, 7'h06, 2'h0, RES_IGN, 1'b0, 2'h3},
    '{1'b0, FSWP_OP_WR_LOCK, 7'h06, 2'h1, RES_IGN, 1'b0, 2'h3},
    '{1'b0, FSWP_OP_RD_LOCK, 7'h06, 2'h0, RES_OK, 1'b0, 2'h0},
    '{1'b1, FSWP_OP_WR_LOCK, 7'h7F, 2'h2, RES_OK, 1'b0, 2'h0},
    '{1'b1, FSWP_OP_MODIFY, 7'h7F, 2'h0, RES_OK, 1'b0, 2'h0},
    '{1'b0, FSWP_OP_RD_LOCK, 7'h7F, 2'h0, RES_OK, 1'b0, 2'h2}};
  fswp_host h (.clk_i(clk_sys_i), .valid_o(op_valid_i), .kind_o(op_kind_i),
    .sec_o(op_sector_i), .wd_o(lock_wdata_i), .st_o(st));
  fswp_protect dut (.clk_sys_i, .sys_rst_i, .op_valid_i, .op_kind_i,
    .op_sector_i, .lock_wdata_i, .range_size_i(st[3:0]),
    .range_side_select_i(st[4]), .status_write_disable_i(st[5]), .wp_n_i,
    .otp_locked_i, .op_done_o, .op_result_o, .lock_rdata_o, .prot_error_o,
    .write_enable_latch_o, .range_size_o, .range_side_select_o,
    .status_write_disable_o);
  always #10 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Result is only meaningful with the done pulse, so both are checked
  task automatic cmp_res(input fswp_res_t exp);
    cmp_val(4'(op_done_o), 4'h1);
    cmp_val(4'(op_result_o), 4'(exp));
  endtask
  // Sectors covered by size codes 7 down to 0, written out per code
  localparam logic [7:0][7:0] RANGE_LEN = {8'h40, 8'h20, 8'h10, 8'h08,
    8'h04, 8'h02, 8'h01, 8'h00};
  function automatic logic prot(input logic [6:0] s, input logic [3:0] c,
      input logic b);
    logic [7:0] m;
    m = c[3] ? 8'h80 : RANGE_LEN[c[2:0]];
    return b ? ({1'b0, s} < m) : ({1'b0, s} >= 8'h80 - m);
  endfunction
  task automatic mod(input logic [6:0] s, input logic p);
    h.send(1'b1, FSWP_OP_MODIFY, s, 2'h0, st);
    cmp_res(p ? FSWP_RES_REFUSED : FSWP_RES_OK);
    cmp_val(4'(prot_error_o), 4'(p));
    if (p) begin
      h.send(1'b0, FSWP_OP_CLR_FLAG, 7'h00, 2'h0, st);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    cmp_val({op_done_o, prot_error_o, op_result_o}, 4'h0);
    cmp_val(4'(write_enable_latch_o), 4'h0);
    foreach (rows[i]) begin
      h.send(rows[i].we, rows[i].k, rows[i].s, rows[i].w, 6'h00);
      cmp_res(rows[i].r);
      cmp_val(4'(prot_error_o), 4'(rows[i].e));
      cmp_val(4'(lock_rdata_o), 4'(rows[i].rd));
      cmp_val(4'(write_enable_latch_o), 4'h0);
    end
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 16; c++) begin
        h.send(1'b1, FSWP_OP_WR_STATUS, 7'h00, 2'h0, {1'b0, b[0], c[3:0]});
        cmp_val(range_size_o, c[3:0]);
        cmp_val(4'(range_side_select_o), 4'(b[0]));
        for (int k = 0; k < 7; k++) begin
          n = 8'h01 << k;
          sv = '{n - 8'h01, n, 8'h80 - n, 8'h7F - n};
          foreach (sv[j]) begin
            sc = sv[j][6:0];
            mod(sc, prot(sc, c[3:0], b[0]));
          end
        end
      end
    end
    h.send(1'b1, FSWP_OP_WR_STATUS, 7'h00, 2'h0, 6'h20);
    cmp_res(FSWP_RES_OK);
    cmp_val(4'(status_write_disable_o), 4'h1);
    @(posedge clk_sys_i);
    wp_n_i <= 1'b0;
    h.send(1'b1, FSWP_OP_WR_STATUS, 7'h00, 2'h0, 6'h03);
    cmp_res(FSWP_RES_REFUSED);
    cmp_val(4'(prot_error_o), 4'h1);
    cmp_val(range_size_o, 4'h0);
    h.send(1'b0, FSWP_OP_CLR_FLAG, 7'h00, 2'h0, 6'h00);
    @(posedge clk_sys_i);
    wp_n_i <= 1'b1;
    otp_locked_i <= 1'b1;
    h.send(1'b1, FSWP_OP_OTP_PROG, 7'h00, 2'h0, 6'h00);
    cmp_res(FSWP_RES_REFUSED);
    h.send(1'b1, FSWP_OP_MODIFY, 7'h40, 2'h0, 6'h00);
    cmp_res(FSWP_RES_REFUSED);
    h.send(1'b1, FSWP_OP_WR_LOCK, 7'h40, 2'h1, 6'h00);
    cmp_res(FSWP_RES_REFUSED);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    h.send(1'b0, FSWP_OP_RD_LOCK, 7'h05, 2'h0, 6'h00);
    cmp_val(4'(lock_rdata_o), 4'h0);
    cmp_val({2'h0, prot_error_o, status_write_disable_o}, 4'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
